// ### logic/exec_pkg.sv
// Opcodes, timing, flag layout and types for the execution block
package exec_pkg;
  // ==========================================
  // Opcodes
  localparam logic [7:0] OPC_SP_DEC = 8'h34;
  localparam logic [7:0] OPC_IX_DEC = 8'h09;
  localparam logic [7:0] OPC_SP_INC = 8'h31;
  localparam logic [7:0] OPC_IX_INC = 8'h08;
  localparam logic [7:0] OPC_XOR_A_LIT = 8'h88;
  localparam logic [7:0] OPC_XOR_A_PAGE = 8'h98;
  localparam logic [7:0] OPC_XOR_A_FULL = 8'hb8;
  localparam logic [7:0] OPC_XOR_A_IDX = 8'ha8;
  localparam logic [7:0] OPC_XOR_B_LIT = 8'hc8;
  localparam logic [7:0] OPC_XOR_B_PAGE = 8'hd8;
  localparam logic [7:0] OPC_XOR_B_FULL = 8'hf8;
  localparam logic [7:0] OPC_XOR_B_IDX = 8'he8;
  localparam logic [7:0] OPC_INC_A = 8'h4c;
  localparam logic [7:0] OPC_INC_B = 8'h5c;
  localparam logic [7:0] OPC_INC_FULL = 8'h7c;
  localparam logic [7:0] OPC_INC_IDX = 8'h6c;
  localparam logic [7:0] OPC_JUMP_FULL = 8'h7e;
  localparam logic [7:0] OPC_JUMP_IDX = 8'h6e;
  localparam logic [7:0] OPC_CALL_FULL = 8'hbd;
  localparam logic [7:0] OPC_CALL_IDX = 8'had;
  // ==========================================
  // Cycle counts and instruction lengths
  localparam logic [2:0] CYC_IMPLIED = 3'h3;
  localparam logic [2:0] CYC_LIT = 3'h2;
  localparam logic [2:0] CYC_PAGE = 3'h3;
  localparam logic [2:0] CYC_FULL = 3'h4;
  localparam logic [2:0] CYC_IDX = 3'h4;
  localparam logic [2:0] CYC_ACC_INC = 3'h2;
  localparam logic [2:0] CYC_MEM_INC = 3'h6;
  localparam logic [2:0] CYC_JUMP = 3'h3;
  localparam logic [2:0] CYC_CALL = 3'h6;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  // ==========================================
  // Condition flags and reset values
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 4;
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  localparam logic [5:0] FLAGS_RESET = 6'h10;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [7:0] BYTE_MAX_POS = 8'h7f;
  // ==========================================
  // Types
  typedef enum logic [3:0] {
    OP_NONE, OP_SP_DEC, OP_SP_INC, OP_IX_DEC, OP_IX_INC,
    OP_XOR, OP_INC8, OP_JUMP, OP_CALL
  } op_class_t;
  typedef enum logic [2:0] {
    AM_IMPLIED, AM_ACC, AM_LIT, AM_PAGE, AM_FULL, AM_IDX
  } addr_mode_t;
endpackage

// ### logic/opcode_decoder.sv
// Opcode table: class, addressing mode, accumulator, cycles, length
`timescale 1ns/10ps
module opcode_decoder (
  input wire logic [7:0] opcode,
  output exec_pkg::op_class_t op_class,
  output exec_pkg::addr_mode_t mode,
  output logic use_acc_b,
  output logic [2:0] cycles,
  output logic [1:0] length
);
  import exec_pkg::*;

  always_comb begin
    op_class = OP_NONE;
    mode = AM_IMPLIED;
    use_acc_b = 1'b0;
    cycles = CYC_LIT;
    length = LEN_ONE;
    case (opcode)
      OPC_SP_DEC, OPC_SP_INC, OPC_IX_DEC, OPC_IX_INC: begin
        cycles = CYC_IMPLIED;
        case (opcode)
          OPC_SP_DEC: op_class = OP_SP_DEC; // RQ1
          OPC_SP_INC: op_class = OP_SP_INC; // RQ9
          OPC_IX_DEC: op_class = OP_IX_DEC; // RQ2
          default: op_class = OP_IX_INC; // RQ10
        endcase
      end
      OPC_XOR_A_LIT, OPC_XOR_B_LIT: begin
        op_class = OP_XOR; // RQ4 RQ5
        mode = AM_LIT;
        use_acc_b = opcode[6];
        length = LEN_TWO;
      end
      OPC_XOR_A_PAGE, OPC_XOR_B_PAGE: begin
        op_class = OP_XOR; // RQ4 RQ5
        mode = AM_PAGE;
        use_acc_b = opcode[6];
        cycles = CYC_PAGE;
        length = LEN_TWO;
      end
      OPC_XOR_A_FULL, OPC_XOR_B_FULL: begin
        op_class = OP_XOR; // RQ4 RQ5
        mode = AM_FULL;
        use_acc_b = opcode[6];
        cycles = CYC_FULL;
        length = LEN_THREE;
      end
      OPC_XOR_A_IDX, OPC_XOR_B_IDX: begin
        op_class = OP_XOR; // RQ4 RQ5
        mode = AM_IDX;
        use_acc_b = opcode[6];
        cycles = CYC_IDX;
        length = LEN_TWO;
      end
      OPC_INC_A, OPC_INC_B: begin
        op_class = OP_INC8; // RQ8
        mode = AM_ACC;
        use_acc_b = opcode[4];
        cycles = CYC_ACC_INC;
      end
      OPC_INC_FULL, OPC_INC_IDX: begin
        op_class = OP_INC8; // RQ8
        mode = opcode[4] ? AM_FULL : AM_IDX;
        cycles = CYC_MEM_INC;
        length = opcode[4] ? LEN_THREE : LEN_TWO;
      end
      OPC_JUMP_FULL, OPC_JUMP_IDX: begin
        op_class = OP_JUMP; // RQ12
        mode = opcode[4] ? AM_FULL : AM_IDX;
        cycles = CYC_JUMP;
        length = opcode[4] ? LEN_THREE : LEN_TWO;
      end
      OPC_CALL_FULL, OPC_CALL_IDX: begin
        op_class = OP_CALL;
        mode = opcode[4] ? AM_FULL : AM_IDX;
        cycles = CYC_CALL;
        length = opcode[4] ? LEN_THREE : LEN_TWO; // RQ13
      end
      default: op_class = OP_NONE;
    endcase
  end
endmodule

// ### logic/byte_alu.sv
// Eight-bit exclusive OR and add-one with flag results
`timescale 1ns/10ps
module byte_alu (
  input wire logic do_xor,
  input wire logic [7:0] operand_x,
  input wire logic [7:0] operand_m,
  output logic [7:0] result,
  output logic neg,
  output logic zero,
  output logic ovf
);
  import exec_pkg::*;

  assign result = do_xor ? (operand_x ^ operand_m) : 8'(operand_x + 8'h01); // RQ3 RQ6
  assign neg = result[7];
  assign zero = (result == 8'h00);
  assign ovf = do_xor ? 1'b0 : (operand_x == BYTE_MAX_POS); // RQ3 RQ7
endmodule

// ### logic/incdec_xor_jump_exec.sv
// Executes stack/index steps, exclusive OR, add-one, jump and call entry
// Behaviour
// [RQ1] Opcode 34 takes three cycles, lowers the stack pointer by one, keeps all flags.
// [RQ2] Opcode 09 takes three cycles, lowers the index by one and sets only Z from the result.
// [RQ3] Exclusive OR puts acc xor operand in the accumulator, sets N and Z, clears V.
// [RQ4] Accumulator A exclusive OR uses 88, 98, B8, A8 with 2, 3, 4, 4 cycles.
// [RQ5] Accumulator B exclusive OR uses C8, D8, F8, E8 with 2, 3, 4, 4 cycles.
// [RQ6] Add-one increments accumulator or memory byte, sets N, Z and V, keeps C, H, I.
// [RQ7] Add-one sets V exactly when the operand was 7F.
// [RQ8] Add-one uses 4C and 5C in 2 cycles, 7C and 6C on memory in 6 cycles.
// [RQ9] Opcode 31 takes three cycles, raises the stack pointer by one, keeps all flags.
// [RQ10] Opcode 08 takes three cycles, raises the index by one and sets only Z.
// [RQ11] Jump loads the program counter with the effective address and keeps all flags.
// [RQ12] Jump uses 7E for full address and 6E for index offset, each in 3 cycles.
// [RQ13] Call advances the counter by 3 or 2, pushes it low byte first, then jumps.
// [RQ14] Sixteen-bit stack and index steps wrap silently modulo 65536.
`timescale 1ns/10ps
module incdec_xor_jump_exec (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand_hi,
  input wire logic [7:0] operand_lo,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [7:0] acc_a,
  output logic [7:0] acc_b,
  output logic [15:0] stack_ptr,
  output logic [15:0] idxreg,
  output logic [15:0] pc,
  output logic [5:0] flags,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we
);
  import exec_pkg::*;

  typedef enum logic {S_IDLE, S_EXEC} state_t;

  function automatic logic [15:0] step16(input logic [15:0] v, input logic up);
    step16 = up ? 16'(v + 16'h0001) : 16'(v - 16'h0001); // RQ14
  endfunction

  // ==========================================
  // Reset release
  logic rst_meta_n;
  logic rst_sync_n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================
  // Decode and effective address
  op_class_t dec_class;
  addr_mode_t dec_mode;
  logic dec_acc_b;
  logic [2:0] dec_cycles;
  logic [1:0] dec_length;

  opcode_decoder u_dec (
    .opcode(opcode),
    .op_class(dec_class),
    .mode(dec_mode),
    .use_acc_b(dec_acc_b),
    .cycles(dec_cycles),
    .length(dec_length)
  );

  state_t state;
  op_class_t cur_class;
  addr_mode_t cur_mode;
  logic cur_acc_b;
  logic [2:0] cur_cycles;
  logic [1:0] cur_length;
  logic [2:0] step;
  logic [7:0] literal;
  logic [15:0] eff_addr;

  wire accept = (state == S_IDLE) && instr_valid;
  wire is_idle = (state == S_IDLE);
  wire [15:0] idx_offset_addr = 16'(idxreg + {8'h00, operand_lo});
  wire [15:0] dec_addr = (dec_mode == AM_PAGE) ? {8'h00, operand_lo} :
                         (dec_mode == AM_IDX) ? idx_offset_addr :
                         {operand_hi, operand_lo}; // RQ11
  wire commit = (state == S_EXEC) && (step == 3'(cur_cycles - 3'h1));
  wire push_lo = (state == S_EXEC) && (cur_class == OP_CALL) &&
                 (step == 3'(cur_cycles - 3'h2));
  wire push_hi = commit && (cur_class == OP_CALL);
  wire [15:0] next_pc_seq = 16'(pc + {14'h0000, cur_length}); // RQ13

  // ==========================================
  // Byte operation
  wire [7:0] acc_sel = cur_acc_b ? acc_b : acc_a;
  wire [7:0] mem_operand = (cur_mode == AM_LIT) ? literal : mem_rdata;
  wire do_xor = (cur_class == OP_XOR);
  wire [7:0] alu_x = (do_xor || cur_mode == AM_ACC) ? acc_sel : mem_rdata;
  wire [7:0] alu_result;
  wire alu_n;
  wire alu_z;
  wire alu_v;

  byte_alu u_alu (
    .do_xor(do_xor),
    .operand_x(alu_x),
    .operand_m(mem_operand),
    .result(alu_result),
    .neg(alu_n),
    .zero(alu_z),
    .ovf(alu_v)
  );

  wire byte_to_acc = (do_xor || cur_mode == AM_ACC) && cur_class != OP_INC8 ||
                     (cur_class == OP_INC8 && cur_mode == AM_ACC);
  wire mem_inc_write = commit && (cur_class == OP_INC8) && (cur_mode != AM_ACC);
  wire [15:0] next_idx = step16(idxreg, cur_class == OP_IX_INC);
  wire [5:0] byte_flags = {flags[FLAG_H], flags[FLAG_I], alu_n, alu_z, alu_v,
                           flags[FLAG_C]}; // RQ3 RQ6 RQ7
  wire [5:0] idx_flags = {flags[5:3], next_idx == 16'h0000, flags[1:0]}; // RQ2 RQ10

  // ==========================================
  // Sequencer
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= S_IDLE;
      step <= 3'h0;
      cur_class <= OP_NONE;
      cur_mode <= AM_IMPLIED;
      cur_acc_b <= 1'b0;
      cur_cycles <= CYC_LIT;
      cur_length <= LEN_ONE;
      literal <= 8'h00;
      eff_addr <= 16'h0000;
    end else begin
      case (state)
        S_IDLE: begin
          if (accept && dec_class != OP_NONE) begin
            state <= S_EXEC;
            step <= 3'h1;
            cur_class <= dec_class;
            cur_mode <= dec_mode;
            cur_acc_b <= dec_acc_b;
            cur_cycles <= dec_cycles;
            cur_length <= dec_length;
            literal <= operand_lo;
            eff_addr <= dec_addr;
          end
        end
        S_EXEC: begin
          step <= 3'(step + 3'h1);
          if (commit) begin
            state <= S_IDLE;
            step <= 3'h0;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ==========================================
  // Architectural registers
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      acc_a <= 8'h00;
      acc_b <= 8'h00;
      stack_ptr <= SP_RESET;
      idxreg <= 16'h0000;
      pc <= PC_RESET;
      flags <= FLAGS_RESET;
    end else if (commit) begin
      pc <= next_pc_seq;
      case (cur_class)
        OP_SP_DEC: stack_ptr <= step16(stack_ptr, 1'b0); // RQ1
        OP_SP_INC: stack_ptr <= step16(stack_ptr, 1'b1); // RQ9
        OP_IX_DEC, OP_IX_INC: begin
          idxreg <= next_idx; // RQ2 RQ10
          flags <= idx_flags;
        end
        OP_XOR, OP_INC8: begin
          flags <= byte_flags; // RQ3 RQ6
          if (byte_to_acc && cur_acc_b) begin
            acc_b <= alu_result;
          end else if (byte_to_acc) begin
            acc_a <= alu_result;
          end
        end
        OP_JUMP: pc <= eff_addr; // RQ11
        OP_CALL: begin
          pc <= eff_addr; // RQ13
          stack_ptr <= 16'(stack_ptr - 16'h0002);
        end
        default: pc <= next_pc_seq;
      endcase
    end
  end

  // ==========================================
  // Memory port and status
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      done <= commit;
      illegal <= accept && dec_class == OP_NONE;
      busy <= (accept && dec_class != OP_NONE) || (!is_idle && !commit);
      if (accept && dec_class != OP_NONE) begin
        mem_addr <= dec_addr;
      end
      if (push_lo) begin
        mem_addr <= stack_ptr; // RQ13
        mem_wdata <= next_pc_seq[7:0];
        mem_we <= 1'b1;
      end else if (push_hi) begin
        mem_addr <= 16'(stack_ptr - 16'h0001); // RQ13
        mem_wdata <= next_pc_seq[15:8];
        mem_we <= 1'b1;
      end else if (mem_inc_write) begin
        mem_addr <= eff_addr; // RQ6
        mem_wdata <= alu_result;
        mem_we <= 1'b1;
      end
    end
  end

  // ==========================================
  // Checks
  wire [15:0] opnd_word = {operand_hi, operand_lo};

  sequence seq_push_low;
    mem_we && (mem_wdata == $past(next_pc_seq[7:0]));
  endsequence

  sequence seq_push_high;
    mem_we && (mem_addr == 16'($past(stack_ptr, 2) - 16'h0001));
  endsequence

  a_sp_down_flags: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // RQ1
    commit && cur_class == OP_SP_DEC |=> stack_ptr == 16'($past(stack_ptr) - 16'h0001)
      && flags == $past(flags))
    else $error("stack pointer decrement wrong");

  a_idx_down_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // RQ2
    commit && cur_class == OP_IX_DEC |=> idxreg == 16'($past(idxreg) - 16'h0001)
      && flags[FLAG_Z] == (idxreg == 16'h0000) && flags[5:3] == $past(flags[5:3]))
    else $error("index decrement wrong");

  a_xor_result: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // RQ3
    commit && do_xor && !cur_acc_b |=> acc_a == ($past(acc_a) ^ $past(mem_operand))
      && !flags[FLAG_V] && flags[FLAG_N] == acc_a[7] && flags[FLAG_C] == $past(flags[FLAG_C]))
    else $error("exclusive or result wrong");

  a_xor_a_timing: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // RQ4
    accept && opcode == OPC_XOR_A_FULL |-> ##1 (!done) [*3] ##1 done)
    else $error("A full address timing wrong");

  a_xor_b_timing: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // RQ5
    accept && opcode == OPC_XOR_B_PAGE |-> ##1 (!done) [*2] ##1 done)
    else $error("B page zero timing wrong");

  a_inc_overflow: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // RQ7
    commit && cur_class == OP_INC8 |=> flags[FLAG_V] == ($past(alu_x) == BYTE_MAX_POS)
      && flags[FLAG_H] == $past(flags[FLAG_H]))
    else $error("increment overflow wrong");

  a_inc_mem_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // RQ8
    accept && opcode == OPC_INC_FULL |-> ##6 (mem_we && done
      && mem_addr == $past(opnd_word, 6)))
    else $error("memory increment timing wrong");

  a_sp_up_flags: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // RQ9
    commit && cur_class == OP_SP_INC |=> stack_ptr == 16'($past(stack_ptr) + 16'h0001)
      && flags == $past(flags))
    else $error("stack pointer increment wrong");

  a_idx_up_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // RQ10
    commit && cur_class == OP_IX_INC |=> idxreg == 16'($past(idxreg) + 16'h0001)
      && flags[FLAG_Z] == (idxreg == 16'h0000))
    else $error("index increment wrong");

  a_jump_target: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // RQ11 RQ12
    accept && opcode == OPC_JUMP_FULL |-> ##3 (done && pc == $past(opnd_word, 3)
      && flags == $past(flags, 3)))
    else $error("jump target or timing wrong");

  a_call_pushes: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // RQ13
    push_lo |=> seq_push_low ##1 seq_push_high)
    else $error("call return address push wrong");
endmodule

// ### dv/incdec_xor_jump_exec_test.sv
// Self-checking bench for the execution block
`timescale 1ns/10ps
module incdec_xor_jump_exec_test;
  import exec_pkg::*;
  // ==========================================
  // Stimulus rows and bench state
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] md;
    logic [2:0] cyc;
    logic poke;
  } row_t;
  row_t rows [0:26] = '{
    '{8'h09, 8'h00, 8'h00, 8'h00, 3'h3, 1'b0}, '{8'h08, 8'h00, 8'h00, 8'h00, 3'h3, 1'b0},
    '{8'h88, 8'h00, 8'hff, 8'h00, 3'h2, 1'b0}, '{8'h4c, 8'h00, 8'h00, 8'h00, 3'h2, 1'b0},
    '{8'h88, 8'h00, 8'h7f, 8'h00, 3'h2, 1'b0}, '{8'h4c, 8'h00, 8'h00, 8'h00, 3'h2, 1'b0},
    '{8'h34, 8'h00, 8'h00, 8'h00, 3'h3, 1'b0}, '{8'h31, 8'h00, 8'h00, 8'h00, 3'h3, 1'b0},
    '{8'h98, 8'h00, 8'h10, 8'h80, 3'h3, 1'b0}, '{8'hb8, 8'h12, 8'h34, 8'h5a, 3'h4, 1'b0},
    '{8'ha8, 8'h00, 8'h05, 8'h0f, 3'h4, 1'b0}, '{8'hc8, 8'h00, 8'h7f, 8'h00, 3'h2, 1'b0},
    '{8'h5c, 8'h00, 8'h00, 8'h00, 3'h2, 1'b0}, '{8'h08, 8'h00, 8'h00, 8'h00, 3'h3, 1'b0},
    '{8'hd8, 8'h00, 8'h40, 8'hff, 3'h3, 1'b0}, '{8'hf8, 8'h30, 8'h00, 8'h01, 3'h4, 1'b0},
    '{8'he8, 8'h00, 8'h02, 8'h7e, 3'h4, 1'b0}, '{8'h09, 8'h00, 8'h00, 8'h00, 3'h3, 1'b0},
    '{8'h09, 8'h00, 8'h00, 8'h00, 3'h3, 1'b0}, '{8'h7c, 8'h20, 8'h00, 8'h7f, 3'h6, 1'b1},
    '{8'h6c, 8'h00, 8'h10, 8'hff, 3'h6, 1'b0}, '{8'h7e, 8'h12, 8'h34, 8'h00, 3'h3, 1'b0},
    '{8'h6e, 8'h00, 8'h20, 8'h00, 3'h3, 1'b0}, '{8'hbd, 8'h20, 8'h77, 8'h00, 3'h6, 1'b0},
    '{8'had, 8'h00, 8'h04, 8'h00, 3'h6, 1'b0}, '{8'h9d, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0},
    '{8'h01, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0}};
  logic ref_clk;
  logic rst_n;
  logic instr_valid;
  logic [7:0] opcode;
  logic [7:0] operand_hi;
  logic [7:0] operand_lo;
  logic [7:0] mem_rdata;
  logic busy;
  logic done;
  logic illegal;
  logic [7:0] acc_a;
  logic [7:0] acc_b;
  logic [15:0] stack_ptr;
  logic [15:0] idxreg;
  logic [15:0] pc;
  logic [5:0] flags;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic mem_we;
  logic [7:0] m_a;
  logic [7:0] m_b;
  logic [15:0] m_sp;
  logic [15:0] m_ix;
  logic [15:0] m_pc;
  logic [5:0] m_f;
  logic [23:0] exp_wr [$];
  logic [23:0] got_wr [$];
  int mismatches = 0;
  int check_count = 0;

  incdec_xor_jump_exec u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid), .opcode(opcode),
    .operand_hi(operand_hi), .operand_lo(operand_lo), .mem_rdata(mem_rdata),
    .busy(busy), .done(done), .illegal(illegal), .acc_a(acc_a), .acc_b(acc_b),
    .stack_ptr(stack_ptr), .idxreg(idxreg), .pc(pc), .flags(flags),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Compare, model and drive tasks
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic model(input row_t r);
    logic [15:0] ea;
    logic [7:0] m;
    logic [7:0] x;
    logic [15:0] ret;
    logic full;
    full = (r.op[5:4] == 2'h3);
    ea = full ? {r.hi, r.lo} : (r.op[5:4] == 2'h2 ? m_ix + 16'(r.lo) : {8'h00, r.lo});
    m = (r.op[5:4] == 2'h0) ? r.lo : r.md;
    exp_wr.delete();
    if (r.cyc != 3'h0) begin
      m_pc = m_pc + ((r.op[7:4] < 4'h6) ? 16'h1 : (full ? 16'h3 : 16'h2));
    end
    case (r.op)
      8'h34: m_sp = m_sp - 16'h1;
      8'h31: m_sp = m_sp + 16'h1;
      8'h09, 8'h08: begin
        m_ix = (r.op == 8'h09) ? m_ix - 16'h1 : m_ix + 16'h1;
        m_f[FLAG_Z] = (m_ix == 16'h0);
      end
      8'h88, 8'h98, 8'ha8, 8'hb8, 8'hc8, 8'hd8, 8'he8, 8'hf8: begin
        x = (r.op[6] ? m_b : m_a) ^ m;
        if (r.op[6]) m_b = x; else m_a = x;
        m_f[FLAG_N] = x[7];
        m_f[FLAG_Z] = (x == 8'h0);
        m_f[FLAG_V] = 1'b0;
      end
      8'h4c, 8'h5c, 8'h6c, 8'h7c: begin
        x = r.op[5] ? m : (r.op[4] ? m_b : m_a);
        m_f[FLAG_V] = (x == 8'h7f);
        x = x + 8'h1;
        if (r.op[5]) exp_wr.push_back({ea, x});
        else if (r.op[4]) m_b = x;
        else m_a = x;
        m_f[FLAG_N] = x[7];
        m_f[FLAG_Z] = (x == 8'h0);
      end
      8'h7e, 8'h6e: m_pc = ea;
      8'hbd, 8'had: begin
        ret = m_pc;
        exp_wr.push_back({m_sp, ret[7:0]});
        exp_wr.push_back({m_sp - 16'h1, ret[15:8]});
        m_sp = m_sp - 16'h2;
        m_pc = ea;
      end
      default: ;
    endcase
  endtask

  task automatic check_state();
    cmp(24'(acc_a), 24'(m_a));
    cmp(24'(acc_b), 24'(m_b));
    cmp(24'(stack_ptr), 24'(m_sp));
    cmp(24'(idxreg), 24'(m_ix));
    cmp(24'(pc), 24'(m_pc));
    cmp(24'(flags), 24'(m_f));
  endtask

  task automatic run(input row_t r);
    int n;
    logic ill;
    @(negedge ref_clk);
    instr_valid = 1'b1;
    opcode = r.op;
    operand_hi = r.hi;
    operand_lo = r.lo;
    mem_rdata = r.md;
    model(r);
    @(posedge ref_clk);
    #1;
    // Illegal pulse stands only in the cycle right after the taking edge
    ill = (illegal === 1'b1);
    @(negedge ref_clk);
    instr_valid = 1'b0;
    got_wr.delete();
    for (n = 1; n <= 8 && !ill; n++) begin
      @(posedge ref_clk);
      #1;
      if (n == 1) cmp(24'(busy), 24'(r.cyc > 3'h2));
      if (mem_we === 1'b1) got_wr.push_back({mem_addr, mem_wdata});
      if (done === 1'b1) break;
      if (r.poke && n < 3) begin
        @(negedge ref_clk);
        instr_valid = (n == 1);
        opcode = 8'h34;
      end
    end
    // Done is seen one edge short of the cycle count: the taking cycle counts as the first
    cmp(24'(n), (r.cyc == 3'h0) ? 24'h1 : 24'(3'(r.cyc - 3'h1)));
    cmp(24'(ill), 24'(r.cyc == 3'h0));
    check_state();
    cmp(24'(got_wr.size()), 24'(exp_wr.size()));
    foreach (exp_wr[i]) begin
      if (i < got_wr.size()) cmp(got_wr[i], exp_wr[i]);
    end
  endtask

  task automatic do_reset();
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (12) @(negedge ref_clk);
    m_a = 8'h0;
    m_b = 8'h0;
    m_sp = 16'h00ff;
    m_ix = 16'h0;
    m_pc = 16'h0;
    m_f = 6'h10;
    check_state();
    cmp(24'({busy, done, mem_we}), 24'h0);
    rst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    opcode = 8'h0;
    operand_hi = 8'h0;
    operand_lo = 8'h0;
    mem_rdata = 8'h0;
    do_reset();
    foreach (rows[i]) run(rows[i]);
    // Second reset mid-run, then index wrap from a fresh state
    do_reset();
    run(rows[0]);
    run(rows[1]);
    report_and_stop();
  end

  initial begin
    #60000;
    mismatches++;
    report_and_stop();
  end
endmodule
